// [src/adcf_output_stage.sv]
// digital output stage: format, clamp, in-range flag, pipeline and conversion-done clock
// Operation
// RULE1 - 12-bit word; two's complement inverts MSB
// RULE2 - underflow gives code 0, overflow code 4095
// RULE3 - in-range flag high in range, low otherwise
// RULE4 - format select low binary, high two's complement
// RULE5 - chip enable high floats data and flag
// RULE6 - conversion-done clock accompanies the data bus
// RULE7 - delay selects set done-clock edge delay
// RULE8 - both delay selects low floats done clock
// RULE9 - capture logic latches on done-clock edge
// RULE10 - capture logic waits maximum output delay
// RULE11 - result appears two sampling cycles after sample
`include "adcf_regs.svh"

module adcf_output_stage import adcf_pkg::*; #(
    parameter int DATA_W = 12
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    output logic irq,
    input wire logic sampleClk,
    input wire logic [DATA_W-1:0] sampleCode,
    input wire logic sampleUnder,
    input wire logic sampleOver,
    input wire logic formatSelect,
    input wire logic chipEnableN,
    input wire logic edgeDelaySelLo,
    input wire logic edgeDelaySelHi,
    output logic [DATA_W-1:0] resultBus,
    output logic resultBusOe,
    output logic inRangeFlag,
    output logic inRangeFlagOe,
    output logic conversionDoneClock,
    output logic conversionDoneClockOe
);

    // edge delays in cycles: rounded up, never below one cycle
    localparam int DLY01_RAW = (`ADCF_DLY_SEL01_PS + `ADCF_CLK_PERIOD_PS - 1) / `ADCF_CLK_PERIOD_PS;
    localparam int DLY10_RAW = (`ADCF_DLY_SEL10_PS + `ADCF_CLK_PERIOD_PS - 1) / `ADCF_CLK_PERIOD_PS;
    localparam int DLY11_RAW = (`ADCF_DLY_SEL11_PS + `ADCF_CLK_PERIOD_PS - 1) / `ADCF_CLK_PERIOD_PS;
    localparam logic [3:0] DLY01_CYC = 4'((DLY01_RAW < 1) ? 1 : DLY01_RAW);
    localparam logic [3:0] DLY10_CYC = 4'((DLY10_RAW < 1) ? 1 : DLY10_RAW);
    localparam logic [3:0] DLY11_CYC = 4'((DLY11_RAW < 1) ? 1 : DLY11_RAW);
    localparam int SYNC_W = DATA_W + 7;
    localparam int STG_W = DATA_W + 3;

    // the flag shares the result register, so the word must stay below its bit
    if (DATA_W < 2 || DATA_W > `ADCF_RESULT_INRANGE_BIT) begin : g_chkDataW
        $error("adcf_output_stage: DATA_W must lie in 2..12");
    end

    // synchronised pins
    logic [SYNC_W-1:0] pinBundle;
    logic [SYNC_W-1:0] pinSync;
    logic sClk;
    logic [DATA_W-1:0] sCode;
    logic sUnder;
    logic sOver;
    logic sFmt;
    logic sCeN;
    logic sDelLo;
    logic sDelHi;
    adcf_delsel_t delSel;

    // data travels beside the sampling clock so both see the same delay
    assign pinBundle = {sampleClk, sampleCode, sampleUnder, sampleOver, formatSelect, chipEnableN,
                        edgeDelaySelLo, edgeDelaySelHi};

    adcf_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pinIn(pinBundle),
        .syncOut(pinSync)
    );

    assign {sClk, sCode, sUnder, sOver, sFmt, sCeN, sDelLo, sDelHi} = pinSync;
    assign delSel = adcf_delsel_t'({sDelHi, sDelLo});

    // sampling clock edge detection
    logic sClkPrev_q;
    logic sClkPrev_d;
    logic clkRise;
    logic clkFall;

    always_comb begin
        sClkPrev_d = sClk;
        clkRise = sClk && !sClkPrev_q;
        clkFall = !sClk && sClkPrev_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sClkPrev_q <= 1'b0;
        end else begin
            sClkPrev_q <= sClkPrev_d;
        end
    end

    // register state
    logic capEn_q;
    logic capEn_d;
    logic [`ADCF_EV_W-1:0] status_q;
    logic [`ADCF_EV_W-1:0] status_d;
    logic [`ADCF_EV_W-1:0] mask_q;
    logic [`ADCF_EV_W-1:0] mask_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic irq_q;
    logic irq_d;

    // sample pipeline: {valid, under, over, code}
    logic [STG_W-1:0] stageA_q;
    logic [STG_W-1:0] stageA_d;
    logic [STG_W-1:0] stageB_q;
    logic [STG_W-1:0] stageB_d;
    logic [DATA_W-1:0] encWord;
    logic encInRange;
    logic [DATA_W-1:0] bus_q;
    logic [DATA_W-1:0] bus_d;
    logic inRange_q;
    logic inRange_d;
    logic busOe_q;
    logic busOe_d;
    logic flagOe_q;
    logic flagOe_d;
    logic advance;
    logic presenting;
    logic [`ADCF_EV_W-1:0] events;

    assign advance = clkRise && capEn_q;
    assign presenting = advance && stageB_q[STG_W-1];

    // format is applied as the word leaves, so a format change shows on the next word
    adcf_encode #(
        .W(DATA_W)
    ) u_encode (
        .rawCode(stageB_q[DATA_W-1:0]),
        .under(stageB_q[DATA_W+1]),
        .over(stageB_q[DATA_W]),
        .twosComp(sFmt),
        .word(encWord),
        .inRange(encInRange)
    );

    // two sampling edges from capture to bus: A at edge k, B at k+1, bus at k+2
    always_comb begin
        stageA_d = stageA_q;
        stageB_d = stageB_q;
        bus_d = bus_q;
        inRange_d = inRange_q;
        if (advance) begin
            stageA_d = {1'b1, sUnder, sOver, sCode}; // [RULE11]
            stageB_d = stageA_q; // [RULE11]
            if (stageB_q[STG_W-1]) begin
                bus_d = encWord; // [RULE1] [RULE2] [RULE4]
                inRange_d = encInRange; // [RULE3]
            end
        end
        busOe_d = !sCeN; // [RULE5]
        flagOe_d = !sCeN; // [RULE5]
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stageA_q <= '0;
            stageB_q <= '0;
            bus_q <= '0;
            inRange_q <= 1'b0;
            busOe_q <= 1'b0;
            flagOe_q <= 1'b0;
        end else begin
            stageA_q <= stageA_d;
            stageB_q <= stageB_d;
            bus_q <= bus_d;
            inRange_q <= inRange_d;
            busOe_q <= busOe_d;
            flagOe_q <= flagOe_d;
        end
    end

    // conversion-done clock: rises a selected delay after each new word, falls with the sampling clock
    adcf_ccs_state_t ccsState_q;
    adcf_ccs_state_t ccsState_d;
    logic [3:0] ccsCnt_q;
    logic [3:0] ccsCnt_d;
    logic ccs_q;
    logic ccs_d;
    logic ccsOe_q;
    logic ccsOe_d;
    logic [3:0] selDly;

    always_comb begin
        case (delSel)
            ADCF_DEL_SHORT: selDly = DLY01_CYC; // [RULE7]
            ADCF_DEL_MID: selDly = DLY10_CYC; // [RULE7]
            ADCF_DEL_LONG: selDly = DLY11_CYC; // [RULE7]
            default: selDly = DLY01_CYC;
        endcase
    end

    always_comb begin
        ccsState_d = ccsState_q;
        ccsCnt_d = ccsCnt_q;
        ccs_d = ccs_q;
        ccsOe_d = (delSel != ADCF_DEL_OFF); // [RULE8]
        case (ccsState_q)
            ADCF_CCS_IDLE: begin
                if (presenting) begin
                    ccsState_d = ADCF_CCS_WAIT; // [RULE6]
                    ccsCnt_d = selDly - 4'h1;
                end
            end
            ADCF_CCS_WAIT: begin
                if (ccsCnt_q == 4'h0) begin
                    ccsState_d = ADCF_CCS_HIGH;
                    ccs_d = 1'b1; // [RULE6] [RULE7]
                end else begin
                    ccsCnt_d = ccsCnt_q - 4'h1;
                end
            end
            ADCF_CCS_HIGH: begin
                // a new word before the fall still gets its own edge
                if (presenting) begin
                    ccsState_d = ADCF_CCS_WAIT;
                    ccsCnt_d = selDly - 4'h1;
                    ccs_d = 1'b0;
                end else if (clkFall) begin
                    ccsState_d = ADCF_CCS_IDLE;
                    ccs_d = 1'b0;
                end
            end
            default: begin
                ccsState_d = ADCF_CCS_IDLE;
                ccs_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ccsState_q <= ADCF_CCS_IDLE;
            ccsCnt_q <= 4'h0;
            ccs_q <= 1'b0;
            ccsOe_q <= 1'b0;
        end else begin
            ccsState_q <= ccsState_d;
            ccsCnt_q <= ccsCnt_d;
            ccs_q <= ccs_d;
            ccsOe_q <= ccsOe_d;
        end
    end

    // events raised as each word reaches the bus
    always_comb begin
        events = '0;
        events[`ADCF_EV_UNDER_BIT] = presenting && stageB_q[DATA_W+1];
        events[`ADCF_EV_OVER_BIT] = presenting && stageB_q[DATA_W];
        events[`ADCF_EV_WORD_BIT] = presenting;
    end

    // register writes; a new event beats a write-one-to-clear in the same cycle
    always_comb begin
        capEn_d = capEn_q;
        mask_d = mask_q;
        status_d = status_q;
        if (regWrite) begin
            if (regAddr == `ADCF_CTRL_OFS) begin
                capEn_d = regWdata[`ADCF_CTRL_CAPTURE_BIT];
            end else if (regAddr == `ADCF_STATUS_OFS) begin
                status_d = status_q & ~regWdata[`ADCF_EV_W-1:0];
            end else if (regAddr == `ADCF_MASK_OFS) begin
                mask_d = regWdata[`ADCF_EV_W-1:0];
            end
        end
        status_d = status_d | events;
        irq_d = |(status_q & mask_q);
    end

    // read data stand only in the cycle after the strobe; unmapped reads give zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (regRead) begin
            if (regAddr == `ADCF_CTRL_OFS) begin
                rdata_d[`ADCF_CTRL_CAPTURE_BIT] = capEn_q;
            end else if (regAddr == `ADCF_STATUS_OFS) begin
                rdata_d[`ADCF_EV_W-1:0] = status_q;
            end else if (regAddr == `ADCF_MASK_OFS) begin
                rdata_d[`ADCF_EV_W-1:0] = mask_q;
            end else if (regAddr == `ADCF_RESULT_OFS) begin
                rdata_d[DATA_W-1:0] = bus_q;
                rdata_d[`ADCF_RESULT_INRANGE_BIT] = inRange_q;
            end else if (regAddr == `ADCF_PINS_OFS) begin
                rdata_d[`ADCF_PINS_FMT_BIT] = sFmt;
                rdata_d[`ADCF_PINS_CEN_BIT] = sCeN;
                rdata_d[`ADCF_PINS_DELLO_BIT] = sDelLo;
                rdata_d[`ADCF_PINS_DELHI_BIT] = sDelHi;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            capEn_q <= `ADCF_CTRL_RESET;
            status_q <= `ADCF_EV_RESET;
            mask_q <= `ADCF_EV_RESET;
            rdata_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else begin
            capEn_q <= capEn_d;
            status_q <= status_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    // every output straight from a flip-flop
    assign regRdata = rdata_q;
    assign irq = irq_q;
    assign resultBus = bus_q;
    assign resultBusOe = busOe_q;
    assign inRangeFlag = inRange_q;
    assign inRangeFlagOe = flagOe_q;
    assign conversionDoneClock = ccs_q;
    assign conversionDoneClockOe = ccsOe_q;

endmodule

// [pkg/adcf_regs.svh]
// register offsets, field positions, reset values and timing figures of the output stage
`ifndef ADCF_REGS_SVH
`define ADCF_REGS_SVH

// register byte offsets on the plain register port
`define ADCF_CTRL_OFS 8'h00
`define ADCF_STATUS_OFS 8'h04
`define ADCF_MASK_OFS 8'h08
`define ADCF_RESULT_OFS 8'h0c
`define ADCF_PINS_OFS 8'h10

// control register fields
`define ADCF_CTRL_CAPTURE_BIT 0
`define ADCF_CTRL_RESET 1'h1

// event bits, shared by status and mask
`define ADCF_EV_UNDER_BIT 0
`define ADCF_EV_OVER_BIT 1
`define ADCF_EV_WORD_BIT 2
`define ADCF_EV_W 3
`define ADCF_EV_RESET 3'h0

// result register fields
`define ADCF_RESULT_INRANGE_BIT 12

// pins register fields
`define ADCF_PINS_FMT_BIT 0
`define ADCF_PINS_CEN_BIT 1
`define ADCF_PINS_DELLO_BIT 2
`define ADCF_PINS_DELHI_BIT 3

// clock period and edge delays of the conversion-done clock, in picoseconds
`define ADCF_CLK_PERIOD_PS 40000
`define ADCF_DLY_SEL01_PS 300
`define ADCF_DLY_SEL10_PS 1300
`define ADCF_DLY_SEL11_PS 2300

`endif

// [pkg/adcf_pkg.sv]
// types shared by the output stage modules
package adcf_pkg;

    // conversion-done clock generator states, one-hot
    typedef enum logic [2:0] {
        ADCF_CCS_IDLE = 3'b001,
        ADCF_CCS_WAIT = 3'b010,
        ADCF_CCS_HIGH = 3'b100
    } adcf_ccs_state_t;

    // edge delay select, {hi, lo}
    typedef enum logic [1:0] {
        ADCF_DEL_OFF = 2'b00,
        ADCF_DEL_SHORT = 2'b01,
        ADCF_DEL_MID = 2'b10,
        ADCF_DEL_LONG = 2'b11
    } adcf_delsel_t;

endpackage

// [src/adcf_sync.sv]
// two-flop synchroniser for a bundle of pin inputs
module adcf_sync import adcf_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // refused while elaborating, before any flop exists
    if (WIDTH < 1) begin : g_chkWidth
        $error("adcf_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_comb begin
        meta_d = pinIn;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign syncOut = sync_q;

endmodule

// [src/adcf_encode.sv]
// clamps a raw result to the end codes and applies the output format
module adcf_encode import adcf_pkg::*; #(
    parameter int W = 12
) (
    input wire logic [W-1:0] rawCode,
    input wire logic under,
    input wire logic over,
    input wire logic twosComp,
    output logic [W-1:0] word,
    output logic inRange
);

    logic [W-1:0] clamped;

    // the format bit needs at least one bit below it
    if (W < 2) begin : g_chkW
        $error("adcf_encode: W must be at least 2");
    end

    // underflow wins if both flags arrive together
    always_comb begin
        if (under) begin
            clamped = '0; // [RULE2]
        end else if (over) begin
            clamped = '1; // [RULE2]
        end else begin
            clamped = rawCode;
        end
        word = clamped;
        word[W-1] = clamped[W-1] ^ twosComp; // [RULE1] [RULE4]
        inRange = !(under || over); // [RULE3]
    end

endmodule

// [dv/adcf_output_stage_checker.sv]
// port checker for the output stage
`include "adcf_regs.svh"
module adcf_output_stage_checker #(
    parameter int DATA_W = 12
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic irq,
    input wire logic sampleClk,
    input wire logic chipEnableN,
    input wire logic edgeDelaySelLo,
    input wire logic edgeDelaySelHi,
    input wire logic [DATA_W-1:0] resultBus,
    input wire logic resultBusOe,
    input wire logic inRangeFlag,
    input wire logic inRangeFlagOe,
    input wire logic conversionDoneClock,
    input wire logic conversionDoneClockOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // four clocks cover the sync flops plus the output flop
    sequence s_ceHi;
        chipEnableN [*4];
    endsequence
    sequence s_ceLo;
        !chipEnableN [*4];
    endsequence
    sequence s_selOff;
        !(edgeDelaySelLo || edgeDelaySelHi) [*4];
    endsequence
    sequence s_selOn;
        (edgeDelaySelLo || edgeDelaySelHi) [*4];
    endsequence
    sequence s_newWord;
        $changed(resultBus) && resultBusOe && $past(resultBusOe);
    endsequence
    property p_ceFloat;
        s_ceHi |=> !resultBusOe && !inRangeFlagOe;
    endproperty
    property p_ceDrive;
        s_ceLo |=> resultBusOe && inRangeFlagOe;
    endproperty
    property p_selOff;
        s_selOff |=> !conversionDoneClockOe;
    endproperty
    property p_selOn;
        s_selOn |=> conversionDoneClockOe;
    endproperty
    // done clock edge follows each new word
    property p_ccsAfterWord;
        s_newWord ##0 conversionDoneClockOe |=> conversionDoneClock;
    endproperty
    // a word only appears a few clocks after a sampling rise
    property p_wordOnRise;
        s_newWord |-> $past(sampleClk, 2) && !$past(sampleClk, 5);
    endproperty
    property p_flagEnd;
        inRangeFlagOe && !inRangeFlag |-> resultBus inside {12'h000, 12'hfff, 12'h800, 12'h7ff};
    endproperty
    property p_rdZero;
        !$past(regRead) |-> regRdata == 32'h0;
    endproperty
    property p_irqMask;
        regWrite && regAddr == `ADCF_MASK_OFS && regWdata[2:0] == 3'h0 |-> ##2 !irq;
    endproperty
    a_ceFloat: assert property (p_ceFloat)
        else $error("bus driven while disabled");
    a_ceDrive: assert property (p_ceDrive)
        else $error("bus not driven while enabled");
    a_selOff: assert property (p_selOff)
        else $error("done clock driven with selects off");
    a_selOn: assert property (p_selOn)
        else $error("done clock floated with selects on");
    a_ccsAfterWord: assert property (p_ccsAfterWord)
        else $error("no done clock edge after word");
    a_wordOnRise: assert property (p_wordOnRise)
        else $error("word not tied to sampling rise");
    a_flagEnd: assert property (p_flagEnd)
        else $error("flag low on non end code");
    a_rdZero: assert property (p_rdZero)
        else $error("read data outside read cycle");
    a_irqMask: assert property (p_irqMask)
        else $error("irq high after full mask");
endmodule

// [dv/adcf_capture_model.sv]
// capture logic model: latches the result bus on the done clock rise
module adcf_capture_model #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] resultBus,
    input wire logic resultBusOe,
    input wire logic inRangeFlag,
    input wire logic inRangeFlagOe,
    input wire logic conversionDoneClock,
    input wire logic conversionDoneClockOe,
    output logic [W-1:0] capWord,
    output logic capFlag,
    output logic capStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] busHold_q;
    logic flagHold_q;
    logic done_q;
    logic [W-1:0] busSeen;
    logic flagSeen;
    logic done;
    // released lines float, so show a toggling inverse, never a steady old value
    assign busSeen = resultBusOe ? resultBus : ~busHold_q;
    assign flagSeen = inRangeFlagOe ? inRangeFlag : ~flagHold_q;
    assign done = conversionDoneClockOe & conversionDoneClock;
    // latch on the rise, a clock after the bus settled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busHold_q <= '0;
            flagHold_q <= 1'b0;
            done_q <= 1'b0;
            capWord <= '0;
            capFlag <= 1'b0;
            capStrobe <= 1'b0;
        end else begin
            busHold_q <= busSeen;
            flagHold_q <= flagSeen;
            done_q <= done;
            capStrobe <= done & ~done_q;
            if (done & ~done_q) begin
                capWord <= busSeen;
                capFlag <= flagSeen;
            end
        end
    end
endmodule

// [dv/adcf_output_stage_tb.sv]
// self-checking bench for the output stage with a capture model on the bus
module adcf_output_stage_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic sampleClk = 1'b0;
    logic [11:0] sampleCode = 12'h000;
    logic sampleUnder = 1'b0;
    logic sampleOver = 1'b0;
    logic formatSelect = 1'b0;
    logic chipEnableN = 1'b0;
    logic edgeDelaySelLo = 1'b1;
    logic edgeDelaySelHi = 1'b0;
    logic [31:0] regRdata;
    logic irq, resultBusOe, inRangeFlag, inRangeFlagOe, conversionDoneClock, conversionDoneClockOe;
    logic [11:0] resultBus, capWord;
    logic capFlag, capStrobe;
    logic fmtAtRise = 1'b0;
    logic [12:0] lastExp = 13'h0000;
    logic [13:0] pendQ [$];
    logic [13:0] corner [8] = '{14'h0000, 14'h07ff, 14'h0800, 14'h0ffe, 14'h0fff, 14'h2555, 14'h1123, 14'h3fff};
    int bad_count = 0;
    int cmp_count = 0;
    int capCount = 0;
    int seedDummy;
    int snap;
    // 25 MHz system clock
    always #20 clk = ~clk;
    adcf_output_stage dut (.clk, .arst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq,
        .sampleClk, .sampleCode, .sampleUnder, .sampleOver, .formatSelect, .chipEnableN, .edgeDelaySelLo,
        .edgeDelaySelHi, .resultBus, .resultBusOe, .inRangeFlag, .inRangeFlagOe, .conversionDoneClock,
        .conversionDoneClockOe);
    adcf_capture_model cap (.clk, .arst_n, .resultBus, .resultBusOe, .inRangeFlag, .inRangeFlagOe,
        .conversionDoneClock, .conversionDoneClockOe, .capWord, .capFlag, .capStrobe);
    // expected {flag, word}; underflow wins when both ends are flagged
    function automatic logic [12:0] exp_word(input logic [13:0] s, input logic fmt);
        logic [11:0] w;
        w = s[13] ? 12'h000 : (s[12] ? 12'hfff : s[11:0]);
        w[11] = w[11] ^ fmt;
        return {~(s[13] | s[12]), w};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // a full edge passes after the strobe drops, so back-to-back calls never double-assign
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        check(regRdata, exp);
    endtask
    // one 320 ns sampling period; data moves at the fall, far from the rise
    task automatic send(input logic [13:0] s, input logic fmt);
        {sampleUnder, sampleOver, sampleCode} <= s;
        formatSelect <= fmt;
        repeat (4) @(posedge clk);
        sampleClk <= 1'b1;
        fmtAtRise = fmt;
        pendQ.push_back(s);
        repeat (4) @(posedge clk);
        sampleClk <= 1'b0;
    endtask
    // each captured word is the sample from two rises back, in the current format
    always @(posedge clk) begin
        if (capStrobe === 1'b1) begin
            capCount++;
            check(32'(pendQ.size() != 0), 32'h1);
            if (pendQ.size() != 0) begin
                lastExp = exp_word(pendQ.pop_front(), fmtAtRise);
                check({19'h0, capFlag, capWord}, {19'h0, lastExp});
            end
        end
    end
    initial begin
        seedDummy = $urandom(32'he290);
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // reset values, then an unmapped place that ignores writes
        reg_rd(8'h00, 32'h1);
        reg_rd(8'h04, 32'h0);
        reg_rd(8'h08, 32'h0);
        reg_wr(8'h14, 32'hffffffff);
        reg_rd(8'h14, 32'h0);
        // corner codes first under the short select, then random traffic under each of the three delay selects that drive the done clock
        for (int d = 1; d < 4; d++) begin
            {edgeDelaySelHi, edgeDelaySelLo} <= 2'(d);
            for (int i = 0; i < 14; i++) begin
                send((d == 1 && i < 8) ? corner[i] : {$urandom % 8 == 0, $urandom % 8 == 1, 12'($urandom)},
                    (d == 1 && i < 8) ? i[0] : 1'($urandom));
            end
        end
        repeat (6) @(posedge clk);
        check(capCount, 40);
        // the result register mirrors the last word and flag on the bus
        reg_rd(8'h0c, {19'h0, lastExp});
        // sticky events, masking and write-one-to-clear
        reg_rd(8'h04, 32'h7);
        reg_wr(8'h08, 32'h4);
        repeat (3) @(posedge clk);
        check(32'(irq), 32'h1);
        reg_wr(8'h08, 32'h0);
        repeat (3) @(posedge clk);
        check(32'(irq), 32'h0);
        reg_wr(8'h08, 32'h4);
        reg_wr(8'h04, 32'h3);
        reg_rd(8'h04, 32'h4);
        reg_wr(8'h04, 32'h4);
        repeat (3) @(posedge clk);
        check(32'(irq), 32'h0);
        reg_rd(8'h04, 32'h0);
        // data and flag released; the done clock answers to the selects alone
        chipEnableN <= 1'b1;
        for (int d = 0; d < 4; d++) begin
            {edgeDelaySelHi, edgeDelaySelLo} <= 2'(d);
            repeat (5) @(posedge clk);
            check(32'({resultBusOe, inRangeFlagOe}), 32'h0);
            check(32'(conversionDoneClockOe), 32'(d != 0));
            reg_rd(8'h10, {28'h0, 2'(d), 1'b1, formatSelect});
        end
        chipEnableN <= 1'b0;
        repeat (5) @(posedge clk);
        check(32'({resultBusOe, inRangeFlagOe}), 32'h3);
        // capture disabled: the pipeline holds still, no done clock edges
        reg_wr(8'h00, 32'h0);
        snap = capCount;
        repeat (3) send(14'h0123, 1'b0);
        repeat (6) @(posedge clk);
        check(snap, capCount);
        // mid-run reset: outputs drop at once, capture comes back enabled
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'({resultBus, resultBusOe, inRangeFlag, inRangeFlagOe, conversionDoneClockOe, irq}), 32'h0);
        arst_n <= 1'b1;
        @(posedge clk);
        reg_rd(8'h00, 32'h1);
        reg_rd(8'h04, 32'h0);
        end_sim();
    end
    // the tests need well under a thousand cycles; eight times that is a hang
    initial begin
        repeat (8000) @(posedge clk);
        bad_count++;
        end_sim();
    end
endmodule

bind adcf_output_stage adcf_output_stage_checker #(.DATA_W(DATA_W)) u_chk (.clk, .arst_n, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .irq, .sampleClk, .chipEnableN, .edgeDelaySelLo, .edgeDelaySelHi, .resultBus,
    .resultBusOe, .inRangeFlag, .inRangeFlagOe, .conversionDoneClock, .conversionDoneClockOe);
